// >>> design/elas_pkg.sv
// Shared constants and types for the effects link and serial audio block.
// Assumes a 100 MHz core clock and a 16 MHz oscillator on a pin.
package elas_pkg;

   // ------------------------------------------------------------
   // Clock rates
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 16_000_000;
   localparam int FX_CLK_FAST_HZ = 64_000_000;
   localparam int FX_CLK_SLOW_HZ = 32_000_000;
   localparam int DAC_HZ = 8_000_000;
   localparam int DAC_FS_RATIO = 256;
   localparam int BITS_PER_WORD = 32;
   localparam int FS_HZ = DAC_HZ / DAC_FS_RATIO;
   localparam int BIT_HZ = FS_HZ * 2 * BITS_PER_WORD;

   // ------------------------------------------------------------
   // Divider counts in oscillator rising edges
   // ------------------------------------------------------------
   localparam int DAC_HALF = OSC_HZ / (2 * DAC_HZ);
   localparam int BCLK_HALF = OSC_HZ / (2 * BIT_HZ);
   localparam int DAC_CNT_W = $clog2(DAC_HALF + 1);
   localparam int BCLK_CNT_W = $clog2(BCLK_HALF + 1);
   localparam logic [DAC_CNT_W-1:0] DAC_LAST = DAC_CNT_W'(DAC_HALF - 1);
   localparam logic [BCLK_CNT_W-1:0] BCLK_LAST =
      BCLK_CNT_W'(BCLK_HALF - 1);

   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int SAMPLE_W = 18;
   localparam int BYTE_W = 9;
   localparam int SLOT_W = $clog2(BITS_PER_WORD);
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(BITS_PER_WORD - 1);
   localparam logic [SLOT_W-1:0] SLOT_DATA_LAST = SLOT_W'(SAMPLE_W - 1);
   localparam logic [SLOT_W-1:0] SLOT_DATA_END = SLOT_W'(SAMPLE_W);
   localparam logic WS_LEFT = 1'b0;
   localparam logic WS_RIGHT = 1'b1;

   typedef struct packed {
      logic [SAMPLE_W-1:0] l;
      logic [SAMPLE_W-1:0] r;
   } elas_pair_t;

   typedef struct packed {
      elas_pair_t synth;
      elas_pair_t send;
   } elas_frame_t;

   typedef struct packed {
      logic osc;
      logic ret;
      logic sel_n;
      logic oe_n;
      logic type_sel;
      logic byte_sel;
   } elas_pins_t;

   localparam elas_pins_t PINS_IDLE = '{osc: 1'b0, ret: 1'b0,
      sel_n: 1'b1, oe_n: 1'b1, type_sel: 1'b0, byte_sel: 1'b0};

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_LEFT = 3'h2,
      ST_RIGHT = 3'h4
   } elas_st_t;

   typedef struct packed {
      elas_pins_t s1;
      elas_pins_t s2;
      logic osc_prev;
      logic [DAC_CNT_W-1:0] dac_cnt;
      logic dac_clk;
      logic [BCLK_CNT_W-1:0] bclk_cnt;
      logic bclk;
      logic ws;
      logic [SLOT_W-1:0] slot;
      elas_st_t st;
      elas_frame_t frame;
      elas_pair_t mix;
      logic [SAMPLE_W-1:0] sh_synth;
      logic [SAMPLE_W-1:0] sh_send;
      logic [SAMPLE_W-1:0] sh_mix;
      logic [SAMPLE_W-1:0] ret_sh;
      logic [SAMPLE_W-1:0] ret_l;
      elas_pair_t ret_out;
      logic ret_valid;
      logic sd_synth;
      logic sd_send;
      logic sd_mix;
      logic sync_n;
      logic [BYTE_W-1:0] send_bus;
      logic send_oe;
      logic ram_ce_n;
      logic reg_sel_n;
   } elas_state_t;

endpackage

// >>> design/elas_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/1ps
module elas_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } elas_fifo_st_t;

   logic [WIDTH-1:0] mem [DEPTH];
   elas_fifo_st_t r;
   elas_fifo_st_t n;
   logic push;
   logic pop;

   assign o_in_ready = (r.cnt != CNT_FULL);
   assign o_out_valid = (r.cnt != '0);
   assign o_out_data = mem[r.rd];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_comb begin
      n = r;
      if (push) begin
         n.wr = (r.wr == PTR_LAST) ? '0 : AW'(r.wr + 1'b1);
      end
      if (pop) begin
         n.rd = (r.rd == PTR_LAST) ? '0 : AW'(r.rd + 1'b1);
      end
      if (push && !pop) begin
         n.cnt = (AW + 1)'(r.cnt + 1'b1);
      end else if (pop && !push) begin
         n.cnt = (AW + 1)'(r.cnt - 1'b1);
      end
      if (i_srst) begin
         n = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      r <= n;
      if (push) begin
         mem[r.wr] <= i_in_data;
      end
   end

endmodule

// >>> design/elas_top.sv
// Effects link and four-line serial audio block of the synthesizer.
// Assumes pins reach it unsynchronised; the PLL taps arrive as clocks.
//
// Overview of operation
// RL1: Effects master clock runs at 64 MHz.
// RL2: Effects master clock switchable to 32 MHz.
// RL3: Register select low during controller effects access.
// RL4: Select and output-enable low make a request.
// RL5: Data-type select picks delay RAM or device.
// RL6: Byte select puts high or low byte out.
// RL7: Nine-bit send bus released when idle.
// RL8: RAM enable low when select low, type low.
// RL9: Sync pulse low marks each frame start.
// RL10: DAC master clock at 256 times word rate.
// RL11: Synthesis audio on primary serial line.
// RL12: Effects send audio on its own line.
// RL13: Effects return received serially.
// RL14: Mix line carries synthesis plus return.
// RL15: One bit clock times all four lines.
// RL16: One word select frames all four lines.
// RL17: Audio clocks derived from oscillator only.
// RL18: Synthesis clock is four times oscillator.
// RL19: MSB first, data changes on falling edge.
// RL20: Send bus driven only for device-sourced requests.
`timescale 1ns/1ps
module elas_top #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pll_clk_x4,
   input wire logic i_pll_clk_x2,
   input wire logic i_fx_clock_slow,
   output logic o_effects_master_clock,
   output logic o_synth_clock,
   input wire logic i_mcu_effects_access,
   output logic o_effects_reg_select_n,
   input wire logic i_effects_request_select_n,
   input wire logic i_effects_request_oe_n,
   input wire logic i_effects_data_type_select,
   input wire logic i_effects_byte_select,
   output logic [elas_pkg::BYTE_W-1:0] o_effects_send_bus,
   output logic o_effects_send_bus_oe,
   output logic o_delay_ram_chip_enable_n,
   output logic o_effects_sync_n,
   input wire logic i_osc_clk,
   output logic o_dac_master_clock,
   output logic o_audio_bit_clock,
   output logic o_audio_word_select,
   output logic o_synth_serial_out,
   output logic o_effects_send_serial_out,
   input wire logic i_effects_return_serial_in,
   output logic o_mix_serial_out,
   input wire logic i_sample_valid,
   output logic o_sample_ready,
   input wire elas_pkg::elas_frame_t i_sample,
   output logic o_return_valid,
   output elas_pkg::elas_pair_t o_return_sample
);
   localparam int SW = elas_pkg::SAMPLE_W;
   localparam int BW = elas_pkg::BYTE_W;

   elas_pkg::elas_state_t r;
   elas_pkg::elas_state_t n;
   logic fifo_valid;
   logic fifo_pop;
   elas_pkg::elas_frame_t fifo_data;

   // ------------------------------------------------------------
   // Saturating mix of two signed samples
   // ------------------------------------------------------------
   function automatic logic [SW-1:0] sat_add(input logic [SW-1:0] a,
                                             input logic [SW-1:0] b);
      logic [SW:0] s;
      s = {a[SW-1], a} + {b[SW-1], b};
      if (s[SW] != s[SW-1]) begin
         sat_add = {s[SW], {(SW - 1){~s[SW]}}};
      end else begin
         sat_add = s[SW-1:0];
      end
   endfunction

   // ------------------------------------------------------------
   // Sample FIFO
   // ------------------------------------------------------------
   elas_fifo #(
      .WIDTH($bits(elas_pkg::elas_frame_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_in_valid(i_sample_valid),
      .o_in_ready(o_sample_ready),
      .i_in_data(i_sample),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_data)
   );

   // ------------------------------------------------------------
   // Processor clocks
   // ------------------------------------------------------------
   assign o_effects_master_clock = i_fx_clock_slow ? i_pll_clk_x2 : // RL2
                                   i_pll_clk_x4; // RL1
   assign o_synth_clock = i_pll_clk_x4; // RL18

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic osc_rise;
      logic bfall;
      logic brise;
      logic new_word;
      logic [elas_pkg::SLOT_W-1:0] ns;
      logic req;
      logic [SW-1:0] word;
      elas_pkg::elas_frame_t fr;
      osc_rise = 1'b0;
      bfall = 1'b0;
      brise = 1'b0;
      new_word = 1'b0;
      ns = '0;
      req = 1'b0;
      word = '0;
      fr = '0;
      fifo_pop = 1'b0;
      n = r;
      n.ret_valid = 1'b0;
      n.s1 = '{osc: i_osc_clk, ret: i_effects_return_serial_in,
         sel_n: i_effects_request_select_n, oe_n: i_effects_request_oe_n,
         type_sel: i_effects_data_type_select,
         byte_sel: i_effects_byte_select};
      n.s2 = r.s1;
      n.osc_prev = r.s2.osc;
      osc_rise = r.s2.osc && !r.osc_prev; // RL17
      if (osc_rise) begin
         n.dac_cnt = DAC_CNT_W_next(r.dac_cnt);
         if (r.dac_cnt == elas_pkg::DAC_LAST) begin
            n.dac_cnt = '0;
            n.dac_clk = !r.dac_clk; // RL10
         end
         n.bclk_cnt = BCLK_CNT_W_next(r.bclk_cnt);
         if (r.bclk_cnt == elas_pkg::BCLK_LAST) begin
            n.bclk_cnt = '0;
            n.bclk = !r.bclk; // RL15
            bfall = r.bclk;
            brise = !r.bclk;
         end
      end
      // Return line sampled on the rising bit clock
      if (brise && r.st != elas_pkg::ST_IDLE &&
          r.slot < elas_pkg::SLOT_DATA_END) begin
         n.ret_sh = {r.ret_sh[SW-2:0], r.s2.ret}; // RL13
         if (r.slot == elas_pkg::SLOT_DATA_LAST) begin
            if (r.ws == elas_pkg::WS_LEFT) begin
               n.ret_l = n.ret_sh;
            end else begin
               n.ret_out = '{l: r.ret_l, r: n.ret_sh};
               n.ret_valid = 1'b1;
            end
         end
      end
      // Outputs advance on the falling bit clock
      if (bfall) begin
         ns = elas_pkg::SLOT_W'(r.slot + 1'b1);
         new_word = (r.slot == elas_pkg::SLOT_LAST);
         n.slot = ns;
         n.sync_n = 1'b1;
         n.sh_synth = {r.sh_synth[SW-2:0], 1'b0};
         n.sh_send = {r.sh_send[SW-2:0], 1'b0};
         n.sh_mix = {r.sh_mix[SW-2:0], 1'b0};
         if (new_word) begin
            n.ws = !r.ws; // RL16
            if (r.ws == elas_pkg::WS_RIGHT) begin
               n.st = elas_pkg::ST_LEFT;
               fifo_pop = fifo_valid;
               fr = fifo_valid ? fifo_data : '0;
               n.frame = fr;
               n.mix.l = sat_add(fr.synth.l, r.ret_out.l); // RL14
               n.mix.r = sat_add(fr.synth.r, r.ret_out.r); // RL14
               n.sh_synth = fr.synth.l;
               n.sh_send = fr.send.l;
               n.sh_mix = n.mix.l;
               n.sync_n = 1'b0; // RL9
            end else begin
               n.st = elas_pkg::ST_RIGHT;
               n.sh_synth = r.frame.synth.r;
               n.sh_send = r.frame.send.r;
               n.sh_mix = r.mix.r;
            end
         end
         if (ns < elas_pkg::SLOT_DATA_END && n.st != elas_pkg::ST_IDLE) begin
            n.sd_synth = n.sh_synth[SW-1]; // RL11 RL19
            n.sd_send = n.sh_send[SW-1]; // RL12 RL19
            n.sd_mix = n.sh_mix[SW-1]; // RL14 RL19
         end else begin
            n.sd_synth = 1'b0;
            n.sd_send = 1'b0;
            n.sd_mix = 1'b0;
         end
         if (new_word) begin
            n.sd_synth = n.sh_synth[SW-1];
            n.sd_send = n.sh_send[SW-1];
            n.sd_mix = n.sh_mix[SW-1];
         end
      end
      // Effects request port
      req = !r.s2.sel_n && !r.s2.oe_n; // RL4
      word = (r.ws == elas_pkg::WS_LEFT) ? r.frame.send.l : r.frame.send.r;
      n.send_oe = req && r.s2.type_sel; // RL5 RL7 RL20
      n.send_bus = r.s2.byte_sel ? word[2*BW-1:BW] : word[BW-1:0]; // RL6
      n.ram_ce_n = !(!r.s2.sel_n && !r.s2.type_sel); // RL8
      n.reg_sel_n = !i_mcu_effects_access; // RL3
      if (i_srst) begin
         n = '0;
         n.s1 = elas_pkg::PINS_IDLE;
         n.s2 = elas_pkg::PINS_IDLE;
         n.ws = elas_pkg::WS_RIGHT;
         n.slot = elas_pkg::SLOT_LAST;
         n.st = elas_pkg::ST_IDLE;
         n.sync_n = 1'b1;
         n.ram_ce_n = 1'b1;
         n.reg_sel_n = 1'b1;
      end
   end

   function automatic logic [elas_pkg::DAC_CNT_W-1:0] DAC_CNT_W_next(
      input logic [elas_pkg::DAC_CNT_W-1:0] c);
      DAC_CNT_W_next = elas_pkg::DAC_CNT_W'(c + 1'b1);
   endfunction

   function automatic logic [elas_pkg::BCLK_CNT_W-1:0] BCLK_CNT_W_next(
      input logic [elas_pkg::BCLK_CNT_W-1:0] c);
      BCLK_CNT_W_next = elas_pkg::BCLK_CNT_W'(c + 1'b1);
   endfunction

   always_ff @(posedge i_clk) begin
      r <= n;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_effects_reg_select_n = r.reg_sel_n;
   assign o_effects_send_bus = r.send_oe ? r.send_bus : '0;
   assign o_effects_send_bus_oe = r.send_oe;
   assign o_delay_ram_chip_enable_n = r.ram_ce_n;
   assign o_effects_sync_n = r.sync_n;
   assign o_dac_master_clock = r.dac_clk;
   assign o_audio_bit_clock = r.bclk;
   assign o_audio_word_select = r.ws;
   assign o_synth_serial_out = r.sd_synth;
   assign o_effects_send_serial_out = r.sd_send;
   assign o_mix_serial_out = r.sd_mix;
   assign o_return_valid = r.ret_valid;
   assign o_return_sample = r.ret_out;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence bclk_edge_s;
      $changed(o_audio_bit_clock);
   endsequence

   sequence bclk_hold_s;
      $stable(o_audio_bit_clock) [*8];
   endsequence

   ram_ce_decode_a: assert property ( // RL8
      !$past(i_srst, 3) |-> o_delay_ram_chip_enable_n ==
      ($past(i_effects_request_select_n, 3) ||
       $past(i_effects_data_type_select, 3)))
      else $error("delay RAM enable does not follow select and type");
   send_oe_cause_a: assert property ( // RL20
      o_effects_send_bus_oe |-> !$past(i_srst, 3) &&
      !$past(i_effects_request_select_n, 3) &&
      !$past(i_effects_request_oe_n, 3) &&
      $past(i_effects_data_type_select, 3))
      else $error("send bus driven without device request");
   reg_select_a: assert property ( // RL3
      !$past(i_srst) |->
      o_effects_reg_select_n == !$past(i_mcu_effects_access))
      else $error("register select does not track access");
   bclk_half_a: assert property ( // RL15
      bclk_edge_s |=> bclk_hold_s)
      else $error("bit clock half period too short");
   ws_on_fall_a: assert property ( // RL16
      $changed(o_audio_word_select) |-> $fell(o_audio_bit_clock))
      else $error("word select moved off the falling bit clock");
   data_on_fall_a: assert property ( // RL19
      $changed(o_synth_serial_out) || $changed(o_mix_serial_out) |->
      $fell(o_audio_bit_clock))
      else $error("serial data moved off the falling bit clock");
   dac_half_a: assert property ( // RL10
      $changed(o_dac_master_clock) |=> $stable(o_dac_master_clock) [*4])
      else $error("DAC clock half period too short");
   sync_frame_a: assert property ( // RL9
      $fell(o_effects_sync_n) |->
      $changed(o_audio_word_select) && o_audio_word_select == 1'b0)
      else $error("sync pulse not at left word start");

endmodule

// >>> testbench/elas_fx_model.sv
// Stand-in for the effects processor on the four serial audio lines.
// Assumes bit clock and word select come from the block under test.
`timescale 1ns/1ps
module elas_fx_model (
   input wire logic i_rst,
   input wire logic i_bclk,
   input wire logic i_ws,
   input wire logic i_synth,
   input wire logic i_send,
   input wire logic i_mix,
   input wire logic i_sync_n,
   input wire elas_pkg::elas_pair_t i_ret_pair,
   output logic o_ret,
   output int o_frames,
   output int o_errs
);
   elas_pkg::elas_frame_t got_q[$];
   elas_pkg::elas_pair_t mix_q[$];
   elas_pkg::elas_pair_t sent_q[$];
   elas_pkg::elas_pair_t cur;
   logic [35:0] sa, sb, sm;
   logic [5:0] pos;
   logic on, pws;
   initial begin
      o_ret = 1'h0;
      o_frames = 0;
      o_errs = 0;
      on = 1'h0;
      pws = 1'h1;
   end
   // ---
   // Frame tracking and return line
   // ---
   always @(negedge i_bclk) begin
      // Let word select settle after the edge that moved the bit clock
      #1;
      if (i_rst !== 1'h0) begin
         on = 1'h0;
         pws = 1'h1;
      end else begin
         if (i_ws === 1'h0 && pws === 1'h1) begin
            if (on) begin
               got_q.push_back({sa, sb});
               mix_q.push_back(sm);
               o_frames++;
            end
            on = 1'h1;
            pos = 6'h00;
            cur = i_ret_pair;
            sent_q.push_back(cur);
         end else begin
            pos = pos + 6'h01;
         end
         if (on && i_ws !== pos[5])
            o_errs++;
         pws = i_ws;
         if (on && pos[4:0] < 5'h12)
            o_ret = pos[5] ? cur.r[5'h11 - pos[4:0]] :
               cur.l[5'h11 - pos[4:0]];
         else
            o_ret = ~o_ret;
      end
   end
   // ---
   // Capture on rising bit clock
   // ---
   always @(posedge i_bclk) begin
      if (on && i_rst === 1'h0) begin
         if (pos[4:0] < 5'h12) begin
            sa = {sa[34:0], i_synth};
            sb = {sb[34:0], i_send};
            sm = {sm[34:0], i_mix};
         end else if ({i_synth, i_send, i_mix} !== 3'h0) begin
            o_errs++;
         end
         if (i_sync_n !== (pos != 6'h00))
            o_errs++;
      end
   end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the effects link and serial audio block.
// Assumes the effects model is compiled before this file.
`timescale 1ns/1ps
module testbench;
   localparam int CYCLE_LIMIT = 90000;
   logic i_clk = 1'h0, i_srst = 1'h1, x4 = 1'h0, x2 = 1'h0, osc = 1'h0;
   logic slow = 1'h0, acc = 1'h0, sel_n = 1'h1, oe_n = 1'h1;
   logic tsel = 1'h0, bsel = 1'h0, svalid = 1'h0, ret_in;
   elas_pkg::elas_frame_t sample = '0;
   elas_pkg::elas_pair_t ret_pair = {18'h1FFFF, 18'h20000};
   elas_pkg::elas_pair_t rsample;
   logic effects_master_clock, synclk, regsel_n, bus_oe, ramce_n, sync_n, dac, bclk;
   logic ws, sd_synth, sd_send, sd_mix, sready, rvalid, pws, pdac, pbclk;
   logic [8:0] bus;
   int seed = 53339, miscompares = 0, samples_checked = 0, cycles = 0;
   int nfs = 0, nret = 0, cd = 0, cb = 0, frames, merrs;
   elas_pkg::elas_frame_t exp_q[$];
   always #5 i_clk = ~i_clk;
   always #8 x4 = ~x4;
   always #16 x2 = ~x2;
   always #80 osc = ~osc;
   elas_top u_elas_top (.i_clk(i_clk), .i_srst(i_srst),
      .i_pll_clk_x4(x4), .i_pll_clk_x2(x2), .i_fx_clock_slow(slow),
      .o_effects_master_clock(effects_master_clock), .o_synth_clock(synclk),
      .i_mcu_effects_access(acc), .o_effects_reg_select_n(regsel_n),
      .i_effects_request_select_n(sel_n), .i_effects_request_oe_n(oe_n),
      .i_effects_data_type_select(tsel), .i_effects_byte_select(bsel),
      .o_effects_send_bus(bus), .o_effects_send_bus_oe(bus_oe),
      .o_delay_ram_chip_enable_n(ramce_n), .o_effects_sync_n(sync_n),
      .i_osc_clk(osc), .o_dac_master_clock(dac), .o_audio_bit_clock(bclk),
      .o_audio_word_select(ws), .o_synth_serial_out(sd_synth),
      .o_effects_send_serial_out(sd_send),
      .i_effects_return_serial_in(ret_in), .o_mix_serial_out(sd_mix),
      .i_sample_valid(svalid), .o_sample_ready(sready), .i_sample(sample),
      .o_return_valid(rvalid), .o_return_sample(rsample));
   elas_fx_model u_elas_fx_model (.i_rst(i_srst), .i_bclk(bclk),
      .i_ws(ws), .i_synth(sd_synth), .i_send(sd_send), .i_mix(sd_mix),
      .i_sync_n(sync_n), .i_ret_pair(ret_pair), .o_ret(ret_in),
      .o_frames(frames), .o_errs(merrs));
   // ---
   // Checking helpers
   // ---
   task automatic chk(input string nm, input logic [35:0] e,
         input logic [35:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk(nm, {35'h0, e}, {35'h0, g});
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic elas_pkg::elas_frame_t frame_at(input int k);
      if (k < 0 || k >= exp_q.size())
         return '0;
      return exp_q[k];
   endfunction
   function automatic logic [17:0] sat_add(input logic [17:0] a,
         input logic [17:0] b);
      logic [18:0] s;
      s = {a[17], a} + {b[17], b};
      if (s[18] != s[17])
         return s[18] ? 18'h20000 : 18'h1FFFF;
      return s[17:0];
   endfunction
   // ---
   // Frame monitor and watchdog
   // ---
   always @(negedge i_clk) begin
      if (i_srst) begin
         nfs = 0;
      end else begin
         if (dac && !pdac)
            cd++;
         if (bclk && !pbclk)
            cb++;
         if (!ws && pws) begin
            if (nfs > 0) begin
               chk("dac_rises", 36'(elas_pkg::DAC_FS_RATIO), 36'(cd));
               chk("bit_rises", 36'h40, 36'(cb));
            end
            nfs++;
            cd = 0;
            cb = 0;
         end
         if (rvalid === 1'h1) begin
            chk("return_pair", u_elas_fx_model.sent_q[nret], rsample);
            nret++;
         end
      end
      pws = ws;
      pdac = dac;
      pbclk = bclk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles >= CYCLE_LIMIT) begin
         miscompares++;
         tally_and_finish;
      end
   end
   // ---
   // Main sequence
   // ---
   initial begin
      elas_pkg::elas_frame_t f;
      elas_pkg::elas_pair_t r;
      logic [17:0] x;
      logic w0;
      int n0;
      repeat (10) @(negedge i_clk);
      chk("reset_outs", 36'({4'hE, 9'h000, 3'h1, 4'h0, 1'h1}),
         36'({regsel_n, ramce_n, sync_n, bus_oe, bus, dac, bclk, ws,
         sd_synth, sd_send, sd_mix, rvalid, sready}));
      i_srst = 1'h0;
      for (int i = 0; i < 9; i++) begin
         f = 72'({$random(seed), $random(seed), $random(seed)});
         if (i == 1)
            f.synth = {18'h1FFFF, 18'h20000};
         svalid = 1'h1;
         sample = f;
         chk1("sample_ready", i < 8, sready);
         if (i < 8)
            exp_q.push_back(f);
         @(negedge i_clk);
      end
      svalid = 1'h0;
      while (frames < 9) begin
         {sel_n, oe_n, tsel, bsel, slow} = 5'($random(seed));
         if (nfs > 0)
            ret_pair = 36'({$random(seed), $random(seed)});
         w0 = ws;
         n0 = nfs;
         for (int c = 0; c < 6; c++) begin
            acc = 1'($random(seed));
            @(negedge i_clk);
            chk1("reg_select_n", ~acc, regsel_n);
         end
         chk1("bus_oe", !sel_n && !oe_n && tsel, bus_oe);
         chk1("ram_ce_n", sel_n || tsel, ramce_n);
         if (ws === w0 && nfs == n0) begin
            f = frame_at(n0 - 1);
            x = ws ? f.send.r : f.send.l;
            chk("send_bus", 36'((!sel_n && !oe_n && tsel) ?
               (bsel ? x[17:9] : x[8:0]) : 9'h000), 36'(bus));
         end
         // Step off the tap edges so the mux output has settled
         #1;
         chk("clock_mux", {34'h0, slow ? x2 : x4, x4},
            {34'h0, effects_master_clock, synclk});
         @(negedge i_clk);
      end
      for (int k = 0; k < 9; k++) begin
         f = frame_at(k);
         r = (k > 0) ? u_elas_fx_model.sent_q[k - 1] : '0;
         chk("synth_pair", f.synth, u_elas_fx_model.got_q[k].synth);
         chk("send_pair", f.send, u_elas_fx_model.got_q[k].send);
         chk("mix_pair", {sat_add(f.synth.l, r.l),
            sat_add(f.synth.r, r.r)}, u_elas_fx_model.mix_q[k]);
      end
      chk("model_errs", 36'h0, 36'(merrs));
      chk1("returns_seen", 1'h1, nret >= 8);
      tally_and_finish;
   end
endmodule
